//--- test/host_ctrl_model.sv
// host board controller model: transmitter-off pin and soft writes
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model
#(
   // one three-byte write frame on a 400 kHz bus, in 100 ns cycles
   parameter int FRAME_CYC = 675
)
(
   // clock
   input  wire logic   clk,
   // pin and soft control
   output var  logic   tx_off,
   output var  logic   soft_tx_off,
   output var  logic   wr_done
);

   initial
   begin
      tx_off      = 1'b0;
      soft_tx_off = 1'b0;
      wr_done     = 1'b0;
   end

   //=========================================================
   // transmitter-off pin
   //=========================================================
   task pin_level(input logic val);
      @(negedge clk);
      tx_off = val;
   endtask : pin_level

   task pin_pulse(input int hold);
      @(negedge clk);
      tx_off = 1'b1;
      repeat (hold) @(negedge clk);
      tx_off = 1'b0;
   endtask : pin_pulse

   //=========================================================
   // soft write: frame time on the wire, then stop strobe
   //=========================================================
   task soft_write(input logic val);
      repeat (FRAME_CYC) @(negedge clk);
      soft_tx_off = val;
      wr_done     = 1'b1;
      @(negedge clk);
      wr_done     = 1'b0;
   endtask : soft_write

   // value change with no stop strobe behind it
   task soft_value(input logic val);
      @(negedge clk);
      soft_tx_off = val;
   endtask : soft_value

endmodule : host_ctrl_model
`default_nettype wire

//--- test/test_xcvr_ctrl.sv
// self-checking testbench of the transceiver control and status block
`timescale 1ns/1ps
`default_nettype none

module test_xcvr_ctrl;

   localparam int INIT_N    = 20;
   localparam int SERIAL_N  = 20;
   localparam int DATA_N    = 40;
   // deadlines in 100 ns cycles
   localparam int OFF_LIM   = 100;
   localparam int ON_LIM    = 10000;
   localparam int FAULT_LIM = 1000;
   localparam int LOSS_LIM  = 1000;
   localparam int SOFT_LIM  = 10000;
   // output vector positions
   localparam int LAS   = 6;
   localparam int TXF   = 5;
   localparam int LOST  = 4;
   localparam int SFLT  = 3;
   localparam int SLOST = 2;
   localparam int DRDY  = 1;
   localparam int SRDY  = 0;

   logic       clk;
   logic       rst;
   logic       tx_off;
   logic       laser_fault;
   logic       signal_lost_det;
   logic       soft_tx_off;
   logic       wr_done;
   logic       laser_en;
   logic       tx_fault;
   logic       signal_lost_flag;
   logic       soft_tx_fault;
   logic       soft_signal_lost;
   logic       data_ready;
   logic       serial_ready;
   logic [6:0] outs;
   int         num_errors;
   int         checks;

   assign outs = {laser_en, tx_fault, signal_lost_flag, soft_tx_fault,
                  soft_signal_lost, data_ready, serial_ready};

   always #50 clk = ~clk;

   //=========================================================
   // design and host model
   //=========================================================
   xcvr_ctrl
   #(
      .INIT_CYC   (INIT_N),
      .SERIAL_CYC (SERIAL_N),
      .DATA_CYC   (DATA_N)
   )
   xcvr_ctrl_inst
   (
      .CLK              (clk),
      .RST              (rst),
      .TX_OFF           (tx_off),
      .LASER_FAULT      (laser_fault),
      .SIGNAL_LOST_DET  (signal_lost_det),
      .SOFT_TX_OFF      (soft_tx_off),
      .WR_DONE          (wr_done),
      .LASER_EN         (laser_en),
      .TX_FAULT         (tx_fault),
      .SIGNAL_LOST_FLAG (signal_lost_flag),
      .SOFT_TX_FAULT    (soft_tx_fault),
      .SOFT_SIGNAL_LOST (soft_signal_lost),
      .DATA_READY       (data_ready),
      .SERIAL_READY     (serial_ready)
   );

   host_ctrl_model host_ctrl_model_inst
   (
      .clk         (clk),
      .tx_off      (tx_off),
      .soft_tx_off (soft_tx_off),
      .wr_done     (wr_done)
   );

   //=========================================================
   // compare, bounded wait and closing report
   //=========================================================
   task stop_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // detector levels, changed at a falling edge
   task set_det(input logic fault, input logic lost);
      @(negedge clk);
      laser_fault     = fault;
      signal_lost_det = lost;
   endtask : set_det

   // poll one output at falling edges, give up after lim cycles
   task wait_out(input int idx, input logic val, input int lim);
      int n;
      n = 0;
      while (outs[idx] !== val && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      check({7'h00, outs[idx]}, {7'h00, val});
      if (outs[idx] !== val)
         stop_test();
   endtask : wait_out

   //=========================================================
   // scenarios
   //=========================================================
   initial
   begin
      clk             = 1'b0;
      rst             = 1'b1;
      laser_fault     = 1'b0;
      signal_lost_det = 1'b0;
      num_errors      = 0;
      checks          = 0;
      repeat (3) @(negedge clk);
      check({1'b0, outs}, 8'h00);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      wait_out(SRDY, 1'b1, SERIAL_N + 3);
      wait_out(LAS, 1'b1, INIT_N + 8);
      wait_out(DRDY, 1'b1, DATA_N + 3);
      // pin off and back on, short of a fault clear
      host_ctrl_model_inst.pin_level(1'b1);
      wait_out(LAS, 1'b0, OFF_LIM);
      repeat (20) @(negedge clk);
      host_ctrl_model_inst.pin_level(1'b0);
      wait_out(LAS, 1'b1, ON_LIM);
      // lost state in and out
      set_det(1'b0, 1'b1);
      wait_out(LOST, 1'b1, LOSS_LIM);
      wait_out(SLOST, 1'b1, SOFT_LIM);
      set_det(1'b0, 1'b0);
      wait_out(LOST, 1'b0, LOSS_LIM);
      wait_out(SLOST, 1'b0, SOFT_LIM);
      // back-to-back soft writes
      host_ctrl_model_inst.soft_write(1'b1);
      wait_out(LAS, 1'b0, SOFT_LIM);
      host_ctrl_model_inst.soft_write(1'b0);
      wait_out(LAS, 1'b1, SOFT_LIM);
      // value change without a write strobe is ignored
      host_ctrl_model_inst.soft_value(1'b1);
      repeat (8) @(negedge clk);
      check({7'h00, laser_en}, 8'h01);
      host_ctrl_model_inst.soft_value(1'b0);
      // fault latch, short pulse kept, full pulse clears
      set_det(1'b1, 1'b0);
      wait_out(TXF, 1'b1, FAULT_LIM);
      wait_out(SFLT, 1'b1, SOFT_LIM);
      set_det(1'b0, 1'b0);
      repeat (200) @(negedge clk);
      check({7'h00, tx_fault}, 8'h01);
      host_ctrl_model_inst.pin_pulse(50);
      repeat (20) @(negedge clk);
      check({7'h00, tx_fault}, 8'h01);
      host_ctrl_model_inst.pin_pulse(110);
      wait_out(TXF, 1'b0, FAULT_LIM);
      wait_out(SFLT, 1'b0, SOFT_LIM);
      wait_out(LAS, 1'b1, INIT_N + 10);
      // latched fault cleared by a power cycle
      set_det(1'b1, 1'b0);
      wait_out(TXF, 1'b1, FAULT_LIM);
      set_det(1'b0, 1'b0);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      check({1'b0, outs}, 8'h00);
      rst = 1'b0;
      wait_out(SRDY, 1'b1, SERIAL_N + 3);
      check({7'h00, tx_fault}, 8'h00);
      stop_test();
   end

endmodule : test_xcvr_ctrl
`default_nettype wire

//--- verilog/level_sync.sv
// three flip-flop synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module level_sync
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // asynchronous levels in, filtered levels out
   input  wire logic [`SYNC_W-1:0]    din,
   output var  logic [`SYNC_W-1:0]    dout
);

   logic [`SYNC_W-1:0] s1_ff;
   logic [`SYNC_W-1:0] s2_ff;
   logic [`SYNC_W-1:0] s3_ff;
   logic [`SYNC_W-1:0] out_ff;
   logic [`SYNC_W-1:0] nxt_out;

   // =========================================================
   // a bit changes once stages two and three agree
   always_comb
   begin
      nxt_out = out_ff;
      for (int i = 0; i < `SYNC_W; i++)
      begin
         if (s2_ff[i] == s3_ff[i])
            nxt_out[i] = s3_ff[i];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         out_ff <= '0;
      end
      else
      begin
         s1_ff  <= din;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign dout = out_ff;

endmodule : level_sync

`default_nettype wire

//--- verilog/xcvr_consts.svh
// timing constants for the transceiver control and status block
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

// clock rate in kHz (10 MHz)
`define CLK_KHZ          10000

// pin path times
`define T_OFF_US         10
`define T_ON_MS          1
`define T_FAULT_US       100
`define T_RESET_US       10
`define T_LOSS_US        100

// soft path and power-on times
`define T_SOFT_MS        100
`define T_INIT_MS        300
`define T_SERIAL_MS      300
`define T_DATA_MS        1000

// deadlines round down, least times round up
`define OFF_CYC          ((`T_OFF_US * `CLK_KHZ) / 1000)
`define FAULT_CYC        ((`T_FAULT_US * `CLK_KHZ) / 1000)
`define LOSS_CYC         ((`T_LOSS_US * `CLK_KHZ) / 1000)
`define RESET_CYC        ((`T_RESET_US * `CLK_KHZ + 999) / 1000)
`define ON_CYC           (`T_ON_MS * `CLK_KHZ)
`define SOFT_CYC         (`T_SOFT_MS * `CLK_KHZ)
`define INIT_CYC         (`T_INIT_MS * `CLK_KHZ)
`define SERIAL_CYC       (`T_SERIAL_MS * `CLK_KHZ)
`define DATA_CYC         (`T_DATA_MS * `CLK_KHZ)

// counter and synchroniser widths
`define CNT_W            24
`define HOLD_W           8
`define SYNC_W           3

// reset values
`define RST_CNT          24'h000000
`define RST_HOLD         8'h00

`endif

//--- verilog/xcvr_ctrl.sv
// control and status logic of the pluggable optical transceiver
//
// Operation
// R1: laser off within 10 us after transmitter-off pin rises
// R2: modulated laser back on within 1 ms after the pin falls
// R3: initialisation, fault clear included, done within 300 ms
// R4: transmit fault pin raised within 100 us of a fault; a fault during init raises it only once init ends
// R5: host holds transmitter-off high 10 us to clear a fault
// R6: lost-signal pin follows lost state within 100 us each way
// R7: soft transmitter-off set drops laser within 100 ms
// R8: soft transmitter-off cleared restores laser within 100 ms
// R9: soft transmit fault bit set within 100 ms of a fault; a fault during init sets it only once init ends
// R10: soft lost-signal bit follows lost state within 100 ms
// R11: soft bandwidth select is not implemented, has no effect
// R12: host keeps serial management clock at or below 400 kHz
// R13: analog data ready bit set within 1000 ms of power-on
// R14: serial bus ready within 300 ms of power-on
// R15: soft deadlines start at falling clock after write stop
// R16: transmit fault stays latched until pulse clear or power-on
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module xcvr_ctrl
#(
   parameter int INIT_CYC   = `INIT_CYC,
   parameter int SERIAL_CYC = `SERIAL_CYC,
   parameter int DATA_CYC   = `DATA_CYC
)
(
   // clock and power-on reset
   input  wire logic   CLK,
   input  wire logic   RST,
   // pins and analog detectors, asynchronous
   input  wire logic   TX_OFF,
   input  wire logic   LASER_FAULT,
   input  wire logic   SIGNAL_LOST_DET,
   // soft control from the serial management logic
   input  wire logic   SOFT_TX_OFF,
   input  wire logic   WR_DONE,
   // laser drive
   output var  logic   LASER_EN,
   // status pins
   output var  logic   TX_FAULT,
   output var  logic   SIGNAL_LOST_FLAG,
   // soft status and readiness
   output var  logic   SOFT_TX_FAULT,
   output var  logic   SOFT_SIGNAL_LOST,
   output var  logic   DATA_READY,
   output var  logic   SERIAL_READY
);

   import xcvr_pkg::*;

   // =========================================================
   // declarations
   logic [`SYNC_W-1:0] sync_out;
   logic               tx_off_s;
   logic               fault_s;
   logic               lost_s;

   xcvr_state_t        state_ff;
   xcvr_state_t        nxt_state;
   logic [`CNT_W-1:0]  init_cnt_ff;
   logic [`CNT_W-1:0]  nxt_init_cnt;

   logic [`HOLD_W-1:0] hold_cnt_ff;
   logic [`HOLD_W-1:0] nxt_hold_cnt;
   logic               tx_off_prev_ff;
   logic               hold_ok;
   logic               clear_req;

   logic               soft_off_ff;
   logic               nxt_soft_off;

   logic [`CNT_W-1:0]  pwr_cnt_ff;
   logic [`CNT_W-1:0]  nxt_pwr_cnt;

   logic               laser_en_ff;
   logic               tx_fault_ff;
   logic               lost_ff;
   logic               soft_fault_ff;
   logic               soft_lost_ff;
   logic               data_ready_ff;
   logic               serial_ready_ff;
   logic               nxt_laser_en;
   logic               nxt_tx_fault;
   logic               nxt_data_ready;
   logic               nxt_serial_ready;

   // counter has reached a limit given in cycles
   function automatic logic reached(input logic [`CNT_W-1:0] cnt,
                                    input int                lim);
      reached = (cnt >= lim[`CNT_W-1:0]);
   endfunction : reached

   // =========================================================
   // input synchronisers
   level_sync u_sync
   (
      .clk  (CLK),
      .rst  (RST),
      .din  ({SIGNAL_LOST_DET, LASER_FAULT, TX_OFF}),
      .dout (sync_out)
   );

   assign tx_off_s = sync_out[0];
   assign fault_s  = sync_out[1];
   assign lost_s   = sync_out[2];

   // =========================================================
   // transmitter-off hold time for fault clear
   assign hold_ok   = (hold_cnt_ff == `HOLD_W'(`RESET_CYC));
   assign clear_req = tx_off_prev_ff && !tx_off_s && hold_ok;       // R5

   always_comb
   begin
      nxt_hold_cnt = `RST_HOLD;
      if (tx_off_s)
      begin
         if (hold_ok)
            nxt_hold_cnt = hold_cnt_ff;
         else
            nxt_hold_cnt = hold_cnt_ff + `HOLD_W'(1);
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         hold_cnt_ff    <= `RST_HOLD;
         tx_off_prev_ff <= 1'b0;
      end
      else
      begin
         hold_cnt_ff    <= nxt_hold_cnt;
         tx_off_prev_ff <= tx_off_s;
      end
   end

   // =========================================================
   // init, run and latched fault
   always_comb
   begin
      nxt_state    = state_ff;
      nxt_init_cnt = init_cnt_ff;
      unique case (state_ff)
         ST_INIT:
         begin
            nxt_init_cnt = init_cnt_ff + `CNT_W'(1);
            if (reached(nxt_init_cnt, INIT_CYC))                    // R3
               nxt_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (fault_s)                                            // R4
               nxt_state = ST_FAULT;
         end
         ST_FAULT:
         begin
            if (clear_req)                                          // R16
            begin
               nxt_state    = ST_INIT;                              // R3
               nxt_init_cnt = `RST_CNT;
            end
         end
         default:
         begin
            nxt_state = ST_INIT;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_ff    <= ST_INIT;
         init_cnt_ff <= `RST_CNT;
      end
      else
      begin
         state_ff    <= nxt_state;
         init_cnt_ff <= nxt_init_cnt;
      end
   end

   // =========================================================
   // soft transmitter-off, taken at the write completion edge
   // soft bandwidth select has no path into this logic       R11
   always_comb
   begin
      nxt_soft_off = soft_off_ff;
      if (WR_DONE)
         nxt_soft_off = SOFT_TX_OFF;                                // R15
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         soft_off_ff <= 1'b0;
      else
         soft_off_ff <= nxt_soft_off;
   end

   // =========================================================
   // power-on readiness
   always_comb
   begin
      nxt_pwr_cnt = pwr_cnt_ff;
      if (!reached(pwr_cnt_ff, DATA_CYC))
         nxt_pwr_cnt = pwr_cnt_ff + `CNT_W'(1);
      nxt_data_ready   = reached(nxt_pwr_cnt, DATA_CYC);            // R13
      nxt_serial_ready = reached(nxt_pwr_cnt, SERIAL_CYC);          // R14
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pwr_cnt_ff      <= `RST_CNT;
         data_ready_ff   <= 1'b0;
         serial_ready_ff <= 1'b0;
      end
      else
      begin
         pwr_cnt_ff      <= nxt_pwr_cnt;
         data_ready_ff   <= nxt_data_ready;
         serial_ready_ff <= nxt_serial_ready;
      end
   end

   // =========================================================
   // outputs
   always_comb
   begin
      // laser only in run, with neither pin nor soft bit off
      nxt_laser_en = (nxt_state == ST_RUN) && !tx_off_s         // R1 R2
                     && !nxt_soft_off;                          // R7 R8
      nxt_tx_fault = (nxt_state == ST_FAULT);                   // R4 R16
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         laser_en_ff   <= 1'b0;
         tx_fault_ff   <= 1'b0;
         lost_ff       <= 1'b0;
         soft_fault_ff <= 1'b0;
         soft_lost_ff  <= 1'b0;
      end
      else
      begin
         laser_en_ff   <= nxt_laser_en;
         tx_fault_ff   <= nxt_tx_fault;
         lost_ff       <= lost_s;                                   // R6
         soft_fault_ff <= nxt_tx_fault;                             // R9
         soft_lost_ff  <= lost_s;                                   // R10
      end
   end

   assign LASER_EN         = laser_en_ff;
   assign TX_FAULT         = tx_fault_ff;
   assign SIGNAL_LOST_FLAG = lost_ff;
   assign SOFT_TX_FAULT    = soft_fault_ff;
   assign SOFT_SIGNAL_LOST = soft_lost_ff;
   assign DATA_READY       = data_ready_ff;
   assign SERIAL_READY     = serial_ready_ff;

   // =========================================================
   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // a fault clear: long hold seen, then the pin falls
   sequence s_long_hold;
      tx_off_s && hold_ok;
   endsequence

   sequence s_fault_clear;
      ((state_ff == ST_FAULT) and s_long_hold) ##1 !tx_off_s;
   endsequence

   a_pin_laser_off:
      assert property ($rose(tx_off_s) |=> !LASER_EN)               // R1
      else $error("laser still on after transmitter-off rose");

   a_pin_laser_on:
      assert property ($fell(tx_off_s) && state_ff == ST_RUN        // R2
                       && !fault_s && !nxt_soft_off |=> LASER_EN)
      else $error("laser not restored after transmitter-off fell");

   a_fault_clear_init:
      assert property (s_fault_clear |=> state_ff == ST_INIT        // R3
                       && !TX_FAULT && !LASER_EN)
      else $error("fault clear did not restart init");

   a_init_holds:
      assert property (state_ff == ST_INIT                          // R3
                       && !reached(init_cnt_ff + `CNT_W'(1), INIT_CYC)
                       |=> state_ff == ST_INIT && !LASER_EN)
      else $error("init left before its time");

   a_fault_pin_rise:
      assert property (state_ff == ST_RUN && fault_s                // R4
                       |=> TX_FAULT && !LASER_EN)
      else $error("fault pin late");

   a_short_hold_kept:
      assert property (TX_FAULT && tx_off_s ##1 !tx_off_s           // R5
                       && !hold_ok |=> TX_FAULT)
      else $error("short pulse cleared the fault");

   a_fault_latched:
      assert property (TX_FAULT && !clear_req                       // R16
                       |=> TX_FAULT)
      else $error("fault dropped without a clear");

   a_lost_pin:
      assert property ($changed(lost_s)                             // R6
                       |=> SIGNAL_LOST_FLAG == $past(lost_s))
      else $error("lost-signal pin does not follow detector");

   a_soft_off:
      assert property (WR_DONE && SOFT_TX_OFF |=> !LASER_EN)        // R7
      else $error("soft off did not drop laser");

   a_soft_on:
      assert property (WR_DONE && !SOFT_TX_OFF && !tx_off_s         // R8
                       && nxt_state == ST_RUN |=> LASER_EN)
      else $error("soft on did not restore laser");

   a_soft_write_only:
      assert property (!WR_DONE && !$past(WR_DONE)                  // R15
                       |-> soft_off_ff == $past(soft_off_ff))
      else $error("soft bit changed outside a write");

   a_soft_fault_mirror:
      assert property (SOFT_TX_FAULT == TX_FAULT)                   // R9
      else $error("soft fault bit differs from pin");

   a_soft_lost_mirror:
      assert property ($rose(lost_s) |=> SOFT_SIGNAL_LOST           // R10
                       ##1 SOFT_SIGNAL_LOST == $past(lost_s))
      else $error("soft lost bit late");

   a_ready_order:
      assert property (DATA_READY |-> SERIAL_READY                  // R13
                       && reached(pwr_cnt_ff, DATA_CYC))
      else $error("data ready before its time");

   a_serial_ready:
      assert property ($rose(SERIAL_READY)                          // R14
                       |-> pwr_cnt_ff == SERIAL_CYC[`CNT_W-1:0])
      else $error("serial ready at wrong count");

endmodule : xcvr_ctrl

`default_nettype wire

//--- verilog/xcvr_pkg.sv
// types shared by the transceiver control and status block
`default_nettype none
package xcvr_pkg;

   // gray coded along init -> run -> fault
   typedef enum logic [1:0]
   {
      ST_INIT  = 2'b00,
      ST_RUN   = 2'b01,
      ST_FAULT = 2'b11
   } xcvr_state_t;

endpackage : xcvr_pkg

`default_nettype wire
